// >>> shared/iac_cfg.svh
// Frame codes, offsets and fixed values of the command executor
`ifndef IAC_CFG_SVH
`define IAC_CFG_SVH
`define IAC_FRAME_LEN 4'h9
`define IAC_INS_SET_OUT 8'h0E
`define IAC_INS_GET_IN 8'h0F
`define IAC_INS_ACCUMULATOR_MATH_CMD 8'h13
`define IAC_INS_COMP 8'h14
`define IAC_STAT_OK 8'h64
`define IAC_STAT_BAD_CMD 8'h02
`define IAC_STAT_BAD_VAL 8'h04
`define IAC_HOST_ADDR 8'h02
`define IAC_PORT_ALL 8'hFF
`define IAC_PORT_VOLT 8'h08
`define IAC_BANK_IN 8'h00
`define IAC_BANK_ADC 8'h01
`define IAC_BANK_OUT 8'h02
`define IAC_REG_CTRL 4'h0
`define IAC_REG_ACC 4'h4
`define IAC_REG_STAT 4'h8
`define IAC_CTRL_STANDALONE 0
`define IAC_RST_OUT 8'h00
`define IAC_RST_PULLUP 1'b1
`endif

// >>> shared/iac_pkg.sv
// Types of the command executor
package iac_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] instr;
      logic [7:0] typ;
      logic [7:0] bank;
      logic [31:0] value;
   } iac_frame_s;
   typedef enum logic [7:0] {
      OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_LOAD
   } iac_op_e;
   typedef struct packed {
      logic zero;
      logic eq;
      logic gt;
      logic lt;
   } iac_flags_s;
endpackage

// >>> hw/iac_exec.sv
// I/O and accumulator command executor for nine-byte frames
// Function
// - Frame: address, instruction, type, bank, value MSB first, checksum; set-output is 0E.
// - Set-output bank 2 port 0/1 drives that output to value 0/1.
// - Set-output port 255 bank 2 loads all outputs from value bits 7:0.
// - Set-output all with value -1 takes the output vector from accumulator.
// - Set-output port 0 bank 0 switches all input pull-ups together.
// - Pull-ups are on after reset.
// - Get-input, banks 0/1/2, value ignored, replies OK with port state.
// - Digital reads give 0 or 1, converter reads give 0 to 4095.
// - Standalone get-input loads accumulator; direct mode only replies.
// - Bank 0 ports 0 to 3 read the four general inputs.
// - Get-input port 255 bank 0 reads all inputs into low byte.
// - Bank 1 port 0 reads converter, port 8 reads supply in tenths volt.
// - Bank 2 ports 0/1 read back the driven output states.
// - Calculate applies type 0..9 operation to accumulator and operand.
// - Calculate result goes to accumulator; reply is OK echoing operand.
// - Values are signed 32-bit, value byte 3 most significant.
// - Reply: host address, target address, status, instruction, value, checksum.
// - Compare sets status flags from accumulator versus operand, accumulator kept.
// - Flags serve jump conditions 0..7: ze nz eq ne gt ge lt le.
// - Set-output replies OK with a zero value.
//
// The placing of the registers and strobed register access were left to the implementer.
`include "iac_cfg.svh"
module iac_exec
   import iac_pkg::*;
#(
   parameter logic [7:0] MODULE_ADDR = 8'h01
)
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_tx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   input wire logic [3:0] i_gp_in,
   input wire logic [11:0] i_adc_in0,
   input wire logic [15:0] i_supply_dv,
   output logic [1:0] o_gp_out,
   output logic o_pullup_en,
   input wire logic [2:0] i_cond_sel,
   output logic o_cond_true,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata
);
   logic [7:0] rx_buf_q [0:7];
   logic [3:0] rx_cnt_q;
   logic [7:0] rx_sum_q;
   logic frame_ok_q;
   iac_frame_s frm;
   logic [7:0] tx_buf_q [0:8];
   logic [3:0] tx_idx_q;
   logic tx_busy_q;
   logic standalone_q;
   logic [31:0] acc_q;
   logic [31:0] acc_d;
   logic acc_we;
   logic [7:0] out_q;
   logic pullup_q;
   iac_flags_s flags_q;
   logic [31:0] in_val;
   logic in_ok;
   logic [7:0] stat;
   logic [31:0] rep_val;
   logic go;
   logic [7:0] rsum;

   assign frm = {rx_buf_q[0], rx_buf_q[1], rx_buf_q[2], rx_buf_q[3],
      rx_buf_q[4], rx_buf_q[5], rx_buf_q[6], rx_buf_q[7]};
   assign go = frame_ok_q && frm.addr == MODULE_ADDR && !tx_busy_q;

   // Frame assembly and checksum
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_cnt_q <= 4'h0;
         rx_sum_q <= 8'h00;
         frame_ok_q <= 1'b0;
         for (int i = 0; i < 8; i++)
            rx_buf_q[i] <= 8'h00;
      end
      else
      begin
         frame_ok_q <= 1'b0;
         if (i_rx_valid)
         begin
            if (rx_cnt_q == `IAC_FRAME_LEN - 4'h1)
            begin
               rx_cnt_q <= 4'h0;
               rx_sum_q <= 8'h00;
               frame_ok_q <= (rx_sum_q == i_rx_byte);
            end
            else
            begin
               rx_buf_q[rx_cnt_q[2:0]] <= i_rx_byte;
               rx_sum_q <= rx_sum_q + i_rx_byte;
               rx_cnt_q <= rx_cnt_q + 4'h1;
            end
         end
      end
   end

   // Input port selection
   always_comb
   begin
      in_val = 32'h0000_0000;
      in_ok = 1'b1;
      unique case (frm.bank)
         `IAC_BANK_IN:
            if (frm.typ < 8'h04)
               in_val = {31'h0, i_gp_in[frm.typ[1:0]]};
            else if (frm.typ == `IAC_PORT_ALL)
               in_val = {28'h0, i_gp_in};
            else
               in_ok = 1'b0;
         `IAC_BANK_ADC:
            if (frm.typ == 8'h00)
               in_val = {20'h0, i_adc_in0};
            else if (frm.typ == `IAC_PORT_VOLT)
               in_val = {16'h0, i_supply_dv};
            else
               in_ok = 1'b0;
         `IAC_BANK_OUT:
            if (frm.typ < 8'h02)
               in_val = {31'h0, out_q[frm.typ[0]]};
            else
               in_ok = 1'b0;
         default:
            in_ok = 1'b0;
      endcase
   end

   // Accumulator arithmetic
   always_comb
   begin
      acc_d = acc_q;
      acc_we = 1'b0;
      if (frm.instr == `IAC_INS_ACCUMULATOR_MATH_CMD)
      begin
         acc_we = 1'b1;
         unique case (frm.typ)
            OP_ADD: acc_d = acc_q + frm.value;
            OP_SUB: acc_d = acc_q - frm.value;
            OP_MUL: acc_d = 32'($signed(acc_q) * $signed(frm.value));
            OP_DIV:
               if (frm.value != 32'h0)
                  acc_d = 32'($signed(acc_q) / $signed(frm.value));
               else
                  acc_we = 1'b0;
            OP_MOD:
               if (frm.value != 32'h0)
                  acc_d = 32'($signed(acc_q) % $signed(frm.value));
               else
                  acc_we = 1'b0;
            OP_AND: acc_d = acc_q & frm.value;
            OP_OR: acc_d = acc_q | frm.value;
            OP_XOR: acc_d = acc_q ^ frm.value;
            OP_NOT: acc_d = ~acc_q;
            OP_LOAD: acc_d = frm.value;
            default: acc_we = 1'b0;
         endcase
      end
      else if (frm.instr == `IAC_INS_GET_IN && in_ok && standalone_q)
      begin
         acc_we = 1'b1;
         acc_d = in_val;
      end
   end

   // Reply status and value
   always_comb
   begin
      stat = `IAC_STAT_OK;
      rep_val = 32'h0000_0000;
      unique case (frm.instr)
         `IAC_INS_SET_OUT:
            if (!(frm.bank == `IAC_BANK_OUT && (frm.typ < 8'h02 || frm.typ == `IAC_PORT_ALL))
               && !(frm.bank == `IAC_BANK_IN && frm.typ == 8'h00))
               stat = `IAC_STAT_BAD_VAL;
         `IAC_INS_GET_IN:
            if (in_ok)
               rep_val = in_val;
            else
               stat = `IAC_STAT_BAD_VAL;
         `IAC_INS_ACCUMULATOR_MATH_CMD:
            if (frm.typ > 8'h09)
               stat = `IAC_STAT_BAD_VAL;
            else
               rep_val = frm.value;
         `IAC_INS_COMP: rep_val = 32'h0000_0000;
         default: stat = `IAC_STAT_BAD_CMD;
      endcase
      rsum = `IAC_HOST_ADDR + MODULE_ADDR + stat + frm.instr + rep_val[31:24]
         + rep_val[23:16] + rep_val[15:8] + rep_val[7:0];
   end

   // Accumulator and flags
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         acc_q <= 32'h0000_0000;
         flags_q <= '0;
      end
      else if (go)
      begin
         if (acc_we)
            acc_q <= acc_d;
         if (frm.instr == `IAC_INS_COMP)
         begin
            flags_q.zero <= (acc_q == frm.value);
            flags_q.eq <= (acc_q == frm.value);
            flags_q.gt <= ($signed(acc_q) > $signed(frm.value));
            flags_q.lt <= ($signed(acc_q) < $signed(frm.value));
         end
      end
   end

   // Outputs and pull-ups
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         out_q <= `IAC_RST_OUT;
         pullup_q <= `IAC_RST_PULLUP;
      end
      else if (go && frm.instr == `IAC_INS_SET_OUT)
      begin
         if (frm.bank == `IAC_BANK_OUT && frm.typ < 8'h02)
            out_q[frm.typ[0]] <= frm.value[0];
         else if (frm.bank == `IAC_BANK_OUT && frm.typ == `IAC_PORT_ALL)
         begin
            if (frm.value == 32'hFFFF_FFFF)
               out_q <= acc_q[7:0];
            else
               out_q <= frm.value[7:0];
         end
         else if (frm.bank == `IAC_BANK_IN && frm.typ == 8'h00)
            pullup_q <= frm.value[0];
      end
   end

   // Reply transmitter
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         tx_busy_q <= 1'b0;
         tx_idx_q <= 4'h0;
         o_tx_valid <= 1'b0;
         o_tx_byte <= 8'h00;
         for (int i = 0; i < 9; i++)
            tx_buf_q[i] <= 8'h00;
      end
      else if (!tx_busy_q)
      begin
         o_tx_valid <= 1'b0;
         if (go && !standalone_q)
         begin
            tx_buf_q[0] <= `IAC_HOST_ADDR;
            tx_buf_q[1] <= MODULE_ADDR;
            tx_buf_q[2] <= stat;
            tx_buf_q[3] <= frm.instr;
            tx_buf_q[4] <= rep_val[31:24];
            tx_buf_q[5] <= rep_val[23:16];
            tx_buf_q[6] <= rep_val[15:8];
            tx_buf_q[7] <= rep_val[7:0];
            tx_buf_q[8] <= rsum;
            tx_busy_q <= 1'b1;
            tx_idx_q <= 4'h0;
         end
      end
      else if (!o_tx_valid || i_tx_ready)
      begin
         if (o_tx_valid && tx_idx_q == `IAC_FRAME_LEN)
         begin
            o_tx_valid <= 1'b0;
            tx_busy_q <= 1'b0;
         end
         else if (tx_idx_q != `IAC_FRAME_LEN)
         begin
            o_tx_valid <= 1'b1;
            o_tx_byte <= tx_buf_q[tx_idx_q];
            tx_idx_q <= tx_idx_q + 4'h1;
         end
      end
   end

   // Condition evaluation for jumps
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         o_cond_true <= 1'b0;
      else
         unique case (i_cond_sel)
            3'h0: o_cond_true <= flags_q.zero;
            3'h1: o_cond_true <= !flags_q.zero;
            3'h2: o_cond_true <= flags_q.eq;
            3'h3: o_cond_true <= !flags_q.eq;
            3'h4: o_cond_true <= flags_q.gt;
            3'h5: o_cond_true <= !flags_q.lt;
            3'h6: o_cond_true <= flags_q.lt;
            3'h7: o_cond_true <= !flags_q.gt;
         endcase
   end

   // Register port
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         standalone_q <= 1'b0;
         o_rdata <= 32'h0000_0000;
      end
      else
      begin
         if (i_wr && i_addr == `IAC_REG_CTRL)
            standalone_q <= i_wdata[`IAC_CTRL_STANDALONE];
         o_rdata <= 32'h0000_0000;
         if (i_rd)
            unique case (i_addr)
               `IAC_REG_CTRL: o_rdata <= {31'h0, standalone_q};
               `IAC_REG_ACC: o_rdata <= acc_q;
               `IAC_REG_STAT: o_rdata <= {19'h0, flags_q, pullup_q, out_q};
               default: o_rdata <= 32'h0000_0000;
            endcase
      end
   end

   assign o_gp_out = out_q[1:0];
   assign o_pullup_en = pullup_q;

   property p_pullup_reset;
      @(posedge i_sys_clk) $fell(i_reset) |-> o_pullup_en;
   endproperty
   a_pullup_reset: assert property (p_pullup_reset) else $error("pull-ups off after reset");

   property p_set_one;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_SET_OUT && frm.bank == `IAC_BANK_OUT && frm.typ == 8'h01
      |=> o_gp_out[1] == $past(frm.value[0]);
   endproperty
   a_set_one: assert property (p_set_one) else $error("output 1 not set");

   property p_set_all;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_SET_OUT && frm.bank == `IAC_BANK_OUT && frm.typ == `IAC_PORT_ALL
      && frm.value != 32'hFFFF_FFFF |=> out_q == $past(frm.value[7:0]);
   endproperty
   a_set_all: assert property (p_set_all) else $error("output vector wrong");

   property p_set_acc;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_SET_OUT && frm.bank == `IAC_BANK_OUT && frm.typ == `IAC_PORT_ALL
      && frm.value == 32'hFFFF_FFFF |=> out_q == $past(acc_q[7:0]);
   endproperty
   a_set_acc: assert property (p_set_acc) else $error("output not from accumulator");

   property p_direct_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && !standalone_q && frm.instr == `IAC_INS_GET_IN |=> $stable(acc_q);
   endproperty
   a_direct_keep: assert property (p_direct_keep) else $error("direct read changed accumulator");

   property p_comp_keep;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_COMP |=> $stable(acc_q) && flags_q.eq == ($past(acc_q) == $past(frm.value));
   endproperty
   a_comp_keep: assert property (p_comp_keep) else $error("compare wrong");

   property p_div_zero;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_ACCUMULATOR_MATH_CMD && (frm.typ == 8'h03 || frm.typ == 8'h04) && frm.value == 32'h0
      |=> $stable(acc_q);
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("divide by zero changed accumulator");

   property p_add;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && frm.instr == `IAC_INS_ACCUMULATOR_MATH_CMD && frm.typ == 8'h00 |=> acc_q == $past(acc_q) + $past(frm.value);
   endproperty
   a_add: assert property (p_add) else $error("add wrong");

   property p_bad_sum;
      @(posedge i_sys_clk) disable iff (i_reset)
      i_rx_valid && rx_cnt_q == 4'h8 && rx_sum_q != i_rx_byte |=> !frame_ok_q;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum accepted");

   property p_reply_head;
      @(posedge i_sys_clk) disable iff (i_reset)
      go && !standalone_q |=> ##[1:3] o_tx_valid && o_tx_byte == `IAC_HOST_ADDR;
   endproperty
   a_reply_head: assert property (p_reply_head) else $error("reply head missing");

   c_set: cover property (@(posedge i_sys_clk) go && frm.instr == `IAC_INS_SET_OUT);
   c_get: cover property (@(posedge i_sys_clk) go && frm.instr == `IAC_INS_GET_IN && standalone_q);
   c_mul: cover property (@(posedge i_sys_clk) go && frm.instr == `IAC_INS_ACCUMULATOR_MATH_CMD && frm.typ == 8'h02);
   c_comp: cover property (@(posedge i_sys_clk) go && frm.instr == `IAC_INS_COMP);
endmodule

// >>> dv/iac_host_model.sv
// Host model: sends command frames and collects reply bytes
module iac_host_model
(
   input wire logic i_sys_clk,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] reply_q[$];
   bit slow = 1'b0;
   initial
   begin
      o_rx_valid = 1'b0;
      o_rx_byte = 8'h00;
      o_tx_ready = 1'b0;
   end
   // Reply byte taken when valid meets ready
   always @(posedge i_sys_clk)
   begin
      if (i_tx_valid && o_tx_ready)
         reply_q.push_back(i_tx_byte);
      o_tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
   end
   task automatic send(input logic [7:0] tgt, input logic [7:0] ins, input logic [7:0] typ,
                       input logic [7:0] bank, input logic [31:0] v, input bit bad);
      logic [7:0] b[9];
      logic [7:0] sum;
      b = '{tgt, ins, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      sum = 8'h00;
      for (int k = 0; k < 8; k++)
         sum = sum + b[k];
      b[8] = bad ? ~sum : sum;
      for (int k = 0; k < 9; k++)
      begin
         @(posedge i_sys_clk);
         o_rx_valid <= 1'b1;
         o_rx_byte <= b[k];
      end
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b0;
      o_rx_byte <= ~b[8];
   endtask
endmodule

// >>> dv/io_accumulator_command_exec_tb_top.sv
// Self-checking bench of the command executor
`include "iac_cfg.svh"
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module io_accumulator_command_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rx_valid, tx_ready, tx_valid, pullup_en, cond_true, wr = 1'b0, rd = 1'b0;
   logic [7:0] rx_byte, tx_byte;
   logic [3:0] gp_in = 4'h0, addr = 4'h0;
   logic [11:0] adc = 12'h000;
   logic [15:0] supply = 16'h0000;
   logic [1:0] gp_out;
   logic [2:0] cond_sel = 3'h0;
   logic [31:0] wdata = 32'h0, rdata;
   int error_cnt = 0;
   int n_compared = 0;
   bit alone = 1'b0;
   always #12.5 clk = ~clk;
   iac_host_model iac_host_model_i (.i_sys_clk(clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
      .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_tx_ready(tx_ready));
   iac_exec iac_exec_i (.i_sys_clk(clk), .i_reset(rst), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
      .i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .i_gp_in(gp_in),
      .i_adc_in0(adc), .i_supply_dv(supply), .o_gp_out(gp_out), .o_pullup_en(pullup_en),
      .i_cond_sel(cond_sel), .o_cond_true(cond_true), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata));
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Sends one frame; in direct mode waits for the reply and checks its frame
   task automatic cmd(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] v, output logic [7:0] st, output logic [31:0] rv);
      logic [7:0] q[$];
      logic [7:0] sum;
      int n;
      iac_host_model_i.reply_q.delete();
      iac_host_model_i.send(8'h01, ins, typ, bank, v, 1'b0);
      st = 8'h00;
      rv = 32'h0;
      n = 0;
      if (alone)
      begin
         repeat (6) @(posedge clk);
         `CHK("standalone reply", 0, iac_host_model_i.reply_q.size());
      end
      else
      begin
         while (iac_host_model_i.reply_q.size() < 9 && n < 400)
         begin
            @(posedge clk);
            n++;
         end
         if (n >= 400)
         begin
            error_cnt++;
            tally_and_finish();
         end
         #1;
         q = iac_host_model_i.reply_q;
         sum = 8'h00;
         for (int k = 0; k < 8; k++)
            sum = sum + q[k];
         `CHK("reply host", `IAC_HOST_ADDR, q[0]);
         `CHK("reply target", 8'h01, q[1]);
         `CHK("reply instr", ins, q[3]);
         `CHK("reply sum", sum, q[8]);
         st = q[2];
         rv = {q[4], q[5], q[6], q[7]};
         repeat (3) @(posedge clk);
      end
   endtask
   function automatic logic [31:0] accumulator_math_cmd_ref(input int op, input logic [31:0] a, input logic [31:0] b);
      case (op)
         0: return a + b;
         1: return a - b;
         2: return a * b;
         3: return (b == 0) ? a : 32'($signed(a) / $signed(b));
         4: return (b == 0) ? a : 32'($signed(a) % $signed(b));
         5: return a & b;
         6: return a | b;
         7: return a ^ b;
         8: return ~a;
         default: return b;
      endcase
   endfunction
   function automatic logic cond_ref(input int c, input logic [31:0] a, input logic [31:0] b);
      case (c)
         0, 2: return a == b;
         1, 3: return a != b;
         4: return $signed(a) > $signed(b);
         5: return $signed(a) >= $signed(b);
         6: return $signed(a) < $signed(b);
         default: return $signed(a) <= $signed(b);
      endcase
   endfunction
   initial
   begin
      logic [31:0] rv, acc, opd, cmp[4];
      logic [7:0] st;
      int op;
      cmp = '{32'd99, 32'd100, 32'd101, 32'hFFFFFFFB};
      void'($urandom(44));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("pullup reset", 1'b1, pullup_en);
      reg_rd(`IAC_REG_STAT, rv);
      `CHK("stat pullup", 1'b1, rv[8]);
      reg_rd(4'hC, rv);
      `CHK("unmapped", 32'h0, rv);
      for (int p = 0; p < 2; p++)
      begin
         cmd(`IAC_INS_SET_OUT, p, `IAC_BANK_OUT, 32'h1, st, rv);
         `CHK("set out status", `IAC_STAT_OK, st);
         `CHK("set out value", 32'h0, rv);
         `CHK("out bit", 1'b1, gp_out[p]);
         cmd(`IAC_INS_GET_IN, p, `IAC_BANK_OUT, 32'h0, st, rv);
         `CHK("out readback", 32'h1, rv);
      end
      repeat (4)
      begin
         opd = $urandom_range(255);
         cmd(`IAC_INS_SET_OUT, `IAC_PORT_ALL, `IAC_BANK_OUT, opd, st, rv);
         reg_rd(`IAC_REG_STAT, rv);
         `CHK("out vector", opd[7:0], rv[7:0]);
         `CHK("out pins", opd[1:0], gp_out);
      end
      for (int v = 0; v < 2; v++)
      begin
         cmd(`IAC_INS_SET_OUT, 8'h00, `IAC_BANK_IN, v, st, rv);
         `CHK("pullup", v, pullup_en);
      end
      iac_host_model_i.slow = 1'b1;
      for (int i = 0; i < 21; i++)
      begin
         op = (i + 9) % 10;
         opd = (i > 9 && (op == 3 || op == 4)) ? 32'h0 : $urandom;
         if (i == 20)
         begin
            op = 2;
            opd = 32'hFFFFEC78;
         end
         cmd(`IAC_INS_ACCUMULATOR_MATH_CMD, op, 8'h00, opd, st, rv);
         `CHK("accumulator_math_cmd status", `IAC_STAT_OK, st);
         `CHK("accumulator_math_cmd echo", opd, rv);
         acc = accumulator_math_cmd_ref(op, acc, opd);
         reg_rd(`IAC_REG_ACC, rv);
         `CHK("accumulator_math_cmd acc", acc, rv);
      end
      iac_host_model_i.slow = 1'b0;
      @(posedge clk);
      gp_in <= 4'($urandom);
      adc <= 12'($urandom);
      supply <= 16'($urandom);
      for (int p = 0; p < 4; p++)
      begin
         cmd(`IAC_INS_GET_IN, p, `IAC_BANK_IN, $urandom, st, rv);
         `CHK("get status", `IAC_STAT_OK, st);
         `CHK("get input", gp_in[p], rv);
      end
      cmd(`IAC_INS_GET_IN, 8'h00, `IAC_BANK_ADC, 32'h0, st, rv);
      `CHK("adc", adc, rv);
      cmd(`IAC_INS_GET_IN, `IAC_PORT_VOLT, `IAC_BANK_ADC, 32'h0, st, rv);
      `CHK("supply", supply, rv);
      cmd(8'h01, 8'h00, 8'h00, 32'h0, st, rv);
      `CHK("bad instr status", `IAC_STAT_BAD_CMD, st);
      cmd(`IAC_INS_GET_IN, 8'h05, `IAC_BANK_IN, 32'h0, st, rv);
      `CHK("bad port status", `IAC_STAT_BAD_VAL, st);
      reg_rd(`IAC_REG_ACC, rv);
      `CHK("direct acc kept", acc, rv);
      reg_wr(`IAC_REG_CTRL, 32'h1);
      alone = 1'b1;
      cmd(`IAC_INS_GET_IN, `IAC_PORT_ALL, `IAC_BANK_IN, 32'h0, st, rv);
      reg_rd(`IAC_REG_ACC, rv);
      `CHK("all inputs acc", {4'h0, gp_in}, rv[7:0]);
      cmd(`IAC_INS_SET_OUT, `IAC_PORT_ALL, `IAC_BANK_OUT, 32'hFFFFFFFF, st, rv);
      `CHK("out from acc", gp_in[1:0], gp_out);
      cmd(`IAC_INS_GET_IN, 8'h02, `IAC_BANK_IN, 32'h0, st, rv);
      reg_rd(`IAC_REG_ACC, rv);
      `CHK("standalone acc", gp_in[2], rv);
      for (int k = 0; k < 4; k++)
      begin
         cmd(`IAC_INS_ACCUMULATOR_MATH_CMD, 8'h09, 8'h00, 32'd100, st, rv);
         cmd(`IAC_INS_COMP, 8'h00, 8'h00, cmp[k], st, rv);
         reg_rd(`IAC_REG_ACC, rv);
         `CHK("comp acc kept", 32'd100, rv);
         for (int c = 0; c < 8; c++)
         begin
            @(posedge clk);
            cond_sel <= 3'(c);
            repeat (2) @(posedge clk);
            #1;
            `CHK("condition", cond_ref(c, 32'd100, cmp[k]), cond_true);
         end
      end
      reg_wr(`IAC_REG_CTRL, 32'h0);
      alone = 1'b0;
      iac_host_model_i.reply_q.delete();
      iac_host_model_i.send(8'h01, `IAC_INS_SET_OUT, `IAC_PORT_ALL, `IAC_BANK_OUT, {30'h0, ~gp_in[1:0]}, 1'b1);
      repeat (20) @(posedge clk);
      `CHK("bad sum pins", gp_in[1:0], gp_out);
      `CHK("bad sum reply", 32'h0, iac_host_model_i.reply_q.size());
      iac_host_model_i.send(8'h05, `IAC_INS_SET_OUT, `IAC_PORT_ALL, `IAC_BANK_OUT, {30'h0, ~gp_in[1:0]}, 1'b0);
      repeat (20) @(posedge clk);
      `CHK("other target pins", gp_in[1:0], gp_out);
      `CHK("other target reply", 32'h0, iac_host_model_i.reply_q.size());
      tally_and_finish();
   end
endmodule
